// *** inc/mrp_pkg.sv ***
// mrp_pkg: constants, types and pin bundle for the clocked memory port.
// assumes one system clock; every host pin is resynchronised before use.
// Overview of operation
// R1 - clock edge samples pins, starts access
// R2 - one active-low enable per die
// R3 - high enable deselects die, outputs float
// R4 - host enables one die, all four in burst
// R5 - sampled address selects the accessed word
// R6 - host grounds top address in halfword mode
// R7 - byte mode: upper data lanes float, grounded
// R8 - write enable high writes, low reads
// R9 - output enable low floats the drivers
// R10 - strap low halfword, high byte addressing
// R11 - host ties width strap statically
// R12 - burst request reads by counter, low resets
// R13 - host holds enables, write low in burst
// R14 - sequencing inputs ignored outside burst mode
// R15 - init low, term high, carry low reset
// R16 - counter steps when all three inputs agree; code also holds it while the read buffer is full
// R17 - init low or term high: no read
// R18 - last-address output flags counter at end
// R19 - per-die flag marks corrected single-bit error
// R20 - enable patterns select die, write picks cycle
// R21 - counter starts at zero, steps by one
// R22 - only the reading die's flag is meaningful
package mrp_pkg;
	localparam int DIE_N = 4;
	localparam int DIE_W = 2;
	localparam int ADDR_W = 21;
	localparam int HW_ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int CHK_W = 5;
	localparam int CODE_W = DATA_W + CHK_W;
	localparam int CNT_W = ADDR_W + DIE_W;
	localparam int SYNC_STAGES = 2;
	localparam int BUF_DEPTH = 2;
	localparam real CLK_PERIOD_NS = 8.0;
	// die enable patterns, active low
	localparam logic [DIE_N-1:0] CE_NONE = 4'hF;
	localparam logic [DIE_N-1:0] CE_ALL = 4'h0;
	localparam logic [DIE_N-1:0] CE_DIE0 = 4'hE;
	localparam logic [DIE_N-1:0] CE_DIE1 = 4'hD;
	localparam logic [DIE_N-1:0] CE_DIE2 = 4'hB;
	localparam logic [DIE_N-1:0] CE_DIE3 = 4'h7;
	// burst counter reset value and end values per width mode
	localparam logic [CNT_W-1:0] CNT_ZERO = 23'h00_0000;
	localparam logic [CNT_W-1:0] CNT_LAST_BYTE = 23'h7F_FFFF;
	localparam logic [CNT_W-1:0] CNT_LAST_HALF = 23'h3F_FFFF;
	localparam logic [1:0] LANES_ALL = 2'h3;
	localparam logic [1:0] LANES_LOW = 2'h1;
	localparam logic [1:0] LANES_NONE = 2'h0;
	// port activity, gray coded along off-single-burst
	typedef enum logic [1:0]
	{
		MRP_OFF = 2'b00,
		MRP_SINGLE = 2'b01,
		MRP_BURST = 2'b11,
		MRP_WRITE = 2'b10
	} mrp_mode_t;
	// every host pin, resynchronised as one bundle
	typedef struct packed
	{
		logic [DIE_N-1:0] ce_n;
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic oe;
		logic [DATA_W-1:0] dq;
		logic strap;
		logic req;
		logic init;
		logic term;
		logic carry;
		logic rdy;
		logic flip;
	} mrp_pins_t;
endpackage

// *** rtl/mrp_buf2.sv ***
// mrp_buf2: two-entry valid/ready buffer for read data.
// assumes producer honours in_ready_out; a stall upstream loses no word.
`timescale 1ns/100ps
module mrp_buf2
#(
	parameter int W = 16
)
(
	input wire logic sys_clk_in, // system clock
	input wire logic srst_in, // synchronous reset, high
	input wire logic in_valid_in, // producer offers a word
	output logic in_ready_out, // buffer can take a word
	input wire logic [W-1:0] in_data_in, // offered word
	output logic out_valid_out, // oldest word present
	input wire logic out_ready_in, // consumer takes the word
	output logic [W-1:0] out_data_out // oldest word
);
	typedef struct packed
	{
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0] cnt;
	} mrp_buf_st_t;
	mrp_buf_st_t st_ff;
	mrp_buf_st_t nxt_st;
	logic push;
	logic pop;

	assign in_ready_out = (st_ff.cnt != 2'd2);
	assign out_valid_out = (st_ff.cnt != 2'd0);
	assign out_data_out = st_ff.d0;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// shift on pop, new word lands in first free slot
	always_comb
	begin
		nxt_st = st_ff;
		if (pop)
		begin
			nxt_st.d0 = st_ff.d1;
			nxt_st.cnt = st_ff.cnt - 2'd1;
		end
		if (push)
		begin
			if (nxt_st.cnt == 2'd0)
				nxt_st.d0 = in_data_in;
			else
				nxt_st.d1 = in_data_in;
			nxt_st.cnt = nxt_st.cnt + 2'd1;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule

// *** rtl/mrp_port.sv ***
// mrp_port: four-die clocked memory port with burst read counter and
// single-error-correcting storage per halfword.
// assumes host pins are asynchronous to sys_clk_in and held steady for at
// least three clocks; the strap is tied statically.
`timescale 1ns/100ps
module mrp_port
#(
	parameter int DEPTH_W = mrp_pkg::HW_ADDR_W
)
(
	input wire logic sys_clk_in, // 125 MHz system clock
	input wire logic srst_in, // synchronous reset, high
	input wire logic [3:0] die_en_n_in, // die enables, low active
	input wire logic [20:0] addr_in, // word address
	input wire logic wr_en_in, // high writes, low reads
	input wire logic out_en_in, // low floats data drivers
	input wire logic [15:0] dq_in, // data pins, inbound
	input wire logic byte_width_strap_in, // high byte, low halfword
	input wire logic burst_read_req_in, // burst read mode
	input wire logic burst_init_in, // counter init, low resets
	input wire logic burst_term_in, // counter terminate, high resets
	input wire logic burst_carry_in, // counter carry-in, low resets
	input wire logic dq_ready_in, // host can take next word
	input wire logic ecc_flip_in, // flip one stored bit on write
	output logic [15:0] dq_out, // data pins, outbound
	output logic [1:0] dq_oe_out, // lane enables, high drives
	output logic last_addr_out, // counter at last address
	output logic [3:0] ecc_fix_out // per-die corrected flag
);
	localparam int MEM_N = mrp_pkg::DIE_N << DEPTH_W;

	typedef struct packed
	{
		mrp_pkg::mrp_mode_t mode;
		logic [mrp_pkg::CNT_W-1:0] cnt;
		logic [mrp_pkg::DATA_W-1:0] dq;
		logic [1:0] oe;
		logic have;
		logic last;
		logic [mrp_pkg::DIE_N-1:0] err;
	} mrp_port_st_t;

	mrp_port_st_t st_ff;
	mrp_port_st_t nxt_st;
	mrp_pkg::mrp_pins_t pin_raw;
	mrp_pkg::mrp_pins_t pin;
	logic [mrp_pkg::CODE_W-1:0] mem [MEM_N];

	logic byte_mode;
	logic single;
	logic single_rd;
	logic single_wr;
	logic seq_ok;
	logic seq_bad;
	logic burst_rd;
	logic cnt_step;
	logic [mrp_pkg::DIE_W-1:0] sel_die;
	logic [mrp_pkg::DIE_W-1:0] acc_die;
	logic [mrp_pkg::ADDR_W-1:0] acc_addr;
	logic [DEPTH_W-1:0] acc_idx;
	logic [mrp_pkg::DIE_W+DEPTH_W-1:0] mem_idx;
	logic [mrp_pkg::CODE_W-1:0] rd_code;
	logic [mrp_pkg::CHK_W-1:0] syn;
	logic [mrp_pkg::DATA_W-1:0] fixed;
	logic fix;
	logic [mrp_pkg::DATA_W-1:0] rd_word;
	logic [mrp_pkg::DATA_W-1:0] wr_word;
	logic [mrp_pkg::CODE_W-1:0] wr_code;
	logic [mrp_pkg::CNT_W-1:0] cnt_last;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [mrp_pkg::DATA_W-1:0] buf_out_data;
	logic push;
	logic drive_mode;

	// hamming position of data bit i, skipping the check positions
	function automatic logic [4:0] ecc_pos(input int i);
		logic [4:0] r;
		int k;
		r = '0;
		k = 0;
		for (int j = 3; j < 32; j++)
		begin
			if (((j & (j - 1)) != 0) && (k <= i))
			begin
				if (k == i)
					r = 5'(j);
				k++;
			end
		end
		return r;
	endfunction

	// check bits: xor of positions of all set data bits
	function automatic logic [4:0] ecc_chk(input logic [15:0] d);
		logic [4:0] s;
		s = '0;
		for (int i = 0; i < 16; i++)
		begin
			if (d[i])
				s = s ^ ecc_pos(i);
		end
		return s;
	endfunction

	// all host pins pass two flops before any logic sees them
	assign pin_raw.ce_n = die_en_n_in;
	assign pin_raw.addr = addr_in;
	assign pin_raw.wr = wr_en_in;
	assign pin_raw.oe = out_en_in;
	assign pin_raw.dq = dq_in;
	assign pin_raw.strap = byte_width_strap_in;
	assign pin_raw.req = burst_read_req_in;
	assign pin_raw.init = burst_init_in;
	assign pin_raw.term = burst_term_in;
	assign pin_raw.carry = burst_carry_in;
	assign pin_raw.rdy = dq_ready_in;
	assign pin_raw.flip = ecc_flip_in;

	mrp_sync2 #(.W($bits(mrp_pkg::mrp_pins_t))) u_sync
	(
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.d_in(pin_raw),
		.q_out(pin)
	);

	// die decode; anything but one low enable selects nothing
	always_comb
	begin
		single = !pin.req; // R20
		sel_die = '0;
		case (pin.ce_n) // R2
			mrp_pkg::CE_DIE0: sel_die = 2'd0;
			mrp_pkg::CE_DIE1: sel_die = 2'd1;
			mrp_pkg::CE_DIE2: sel_die = 2'd2;
			mrp_pkg::CE_DIE3: sel_die = 2'd3;
			default: single = 1'b0; // R3
		endcase
	end

	// cycle classification on each synchronised sample
	assign byte_mode = pin.strap; // R10
	assign single_rd = single && !pin.wr; // R8
	assign single_wr = single && pin.wr; // R8
	// sequencing inputs only count while burst is requested
	assign seq_ok = pin.req && pin.init && !pin.term && pin.carry; // R14 R16
	assign seq_bad = pin.req && !seq_ok; // R15
	// init low or term high disables the die even with enables low
	assign burst_rd = seq_ok && (pin.ce_n == mrp_pkg::CE_ALL); // R17
	assign cnt_step = seq_ok && buf_in_ready; // R16

	// access address: pins for single cycles, counter in burst
	always_comb
	begin
		if (pin.req)
		begin
			if (byte_mode)
			begin
				acc_die = st_ff.cnt[22:21];
				acc_addr = st_ff.cnt[20:0];
			end
			else
			begin
				acc_die = st_ff.cnt[21:20];
				acc_addr = {1'b0, st_ff.cnt[19:0]};
			end
		end
		else
		begin
			acc_die = sel_die;
			acc_addr = pin.addr; // R5
		end
	end

	// byte mode: bit 0 picks the lane; halfword mode ignores the top bit
	assign acc_idx = byte_mode ? acc_addr[DEPTH_W:1]
		: acc_addr[DEPTH_W-1:0]; // R6 R10
	assign mem_idx = {acc_die, acc_idx};
	assign rd_code = mem[mem_idx];

	// correct a single flipped bit; check-bit hits only raise the flag
	always_comb
	begin
		syn = ecc_chk(rd_code[15:0]) ^ rd_code[20:16];
		fixed = rd_code[15:0];
		for (int i = 0; i < mrp_pkg::DATA_W; i++)
		begin
			if (syn == ecc_pos(i))
				fixed[i] = !fixed[i];
		end
		fix = (syn != '0); // R19
	end

	// byte reads return one lane in the low bits
	assign rd_word = !byte_mode ? fixed : (acc_addr[0]
		? {8'h00, fixed[15:8]} : {8'h00, fixed[7:0]}); // R7

	// byte writes merge into the corrected halfword before re-encoding
	always_comb
	begin
		wr_word = pin.dq;
		if (byte_mode)
		begin
			wr_word = fixed;
			if (acc_addr[0])
				wr_word[15:8] = pin.dq[7:0];
			else
				wr_word[7:0] = pin.dq[7:0];
		end
		wr_code = {ecc_chk(wr_word), wr_word};
		wr_code[0] = wr_code[0] ^ pin.flip;
	end

	// storage; the edge that sampled the pins starts the write
	always_ff @(posedge sys_clk_in)
	begin
		if (!srst_in && single_wr)
			mem[mem_idx] <= wr_code; // R1 R8
	end

	// reads enter the buffer; a full buffer refuses and stalls the counter
	assign push = (single_rd || burst_rd) && buf_in_ready;

	mrp_buf2 #(.W(mrp_pkg::DATA_W)) u_buf
	(
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.in_valid_in(single_rd || burst_rd),
		.in_ready_out(buf_in_ready),
		.in_data_in(rd_word),
		.out_valid_out(buf_out_valid),
		.out_ready_in(pin.rdy),
		.out_data_out(buf_out_data)
	);

	assign cnt_last = byte_mode ? mrp_pkg::CNT_LAST_BYTE
		: mrp_pkg::CNT_LAST_HALF;

	// next-state: mode, counter, output stage and flags
	always_comb
	begin
		nxt_st = st_ff;
		// mode follows the latest sampled cycle
		if (pin.req)
			nxt_st.mode = burst_rd ? mrp_pkg::MRP_BURST : mrp_pkg::MRP_OFF;
		else if (single)
			nxt_st.mode = pin.wr ? mrp_pkg::MRP_WRITE : mrp_pkg::MRP_SINGLE;
		else
			nxt_st.mode = mrp_pkg::MRP_OFF; // R3
		// counter: leaving burst or a bad sequence returns it to zero
		if (!pin.req || seq_bad)
			nxt_st.cnt = mrp_pkg::CNT_ZERO; // R12 R15 R21
		else if (cnt_step)
			nxt_st.cnt = st_ff.cnt + 23'h00_0001; // R16 R21
		if (!byte_mode)
			nxt_st.cnt[22] = 1'b0;
		nxt_st.last = (nxt_st.cnt == cnt_last); // R18
		// only the die that read gets its flag updated
		if (push)
			nxt_st.err[acc_die] = fix; // R19 R22
		// drain the buffer onto the data pins
		if (buf_out_valid && pin.rdy)
		begin
			nxt_st.dq = buf_out_data;
			nxt_st.have = 1'b1;
		end
		else if (nxt_st.mode == mrp_pkg::MRP_OFF)
			nxt_st.have = 1'b0;
		// float on deselect, write or output enable low
		nxt_st.oe = mrp_pkg::LANES_NONE; // R3 R8 R9
		if (drive_mode && pin.oe && nxt_st.have)
			nxt_st.oe = byte_mode ? mrp_pkg::LANES_LOW
				: mrp_pkg::LANES_ALL; // R7
		case (nxt_st.mode)
			mrp_pkg::MRP_OFF: nxt_st.oe = mrp_pkg::LANES_NONE;
			mrp_pkg::MRP_WRITE: nxt_st.oe = mrp_pkg::LANES_NONE;
			default: ;
		endcase
	end

	// taken from the sampled cycle, not nxt_st, so no comb loop forms
	assign drive_mode = single_rd || burst_rd;

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			st_ff.mode <= mrp_pkg::MRP_OFF;
			st_ff.cnt <= mrp_pkg::CNT_ZERO;
			st_ff.dq <= '0;
			st_ff.oe <= mrp_pkg::LANES_NONE;
			st_ff.have <= 1'b0;
			st_ff.last <= 1'b0;
			st_ff.err <= '0;
		end
		else
			st_ff <= nxt_st; // R1
	end

	// outputs come straight from the state flops
	assign dq_out = st_ff.dq;
	assign dq_oe_out = st_ff.oe;
	assign last_addr_out = st_ff.last;
	assign ecc_fix_out = st_ff.err;

	// checks on the sampled pins and the driven outputs
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_step;
		cnt_step && !seq_bad;
	endsequence

	sequence s_two_steps;
		s_step ##1 s_step;
	endsequence

	a_deselect_float: assert property ( // R3
		(!pin.req && pin.ce_n == mrp_pkg::CE_NONE) |=> dq_oe_out == 2'b00)
		else $error("drivers on while all dies deselected");

	a_write_float: assert property ( // R8
		single_wr |=> dq_oe_out == 2'b00)
		else $error("drivers on during a write cycle");

	a_oe_low_float: assert property ( // R9
		!pin.oe |=> dq_oe_out == 2'b00)
		else $error("drivers on with output enable low");

	a_byte_upper_off: assert property ( // R7
		byte_mode |=> !dq_oe_out[1])
		else $error("upper lane driven in byte mode");

	a_exit_reset: assert property ( // R12
		!pin.req |=> st_ff.cnt == mrp_pkg::CNT_ZERO)
		else $error("counter not cleared outside burst");

	a_seq_reset: assert property ( // R15
		(pin.req && (!pin.init || pin.term || !pin.carry))
		|=> st_ff.cnt == mrp_pkg::CNT_ZERO)
		else $error("counter not cleared by sequencing input");

	a_two_steps: assert property ( // R16
		s_two_steps |=> st_ff.cnt == $past(st_ff.cnt, 2) + 23'h00_0002)
		else $error("counter did not step by one per edge");

	a_no_disabled_read: assert property ( // R17
		(pin.req && (!pin.init || pin.term)) |-> !push)
		else $error("read taken in a disabled burst cycle");

	a_write_keeps_flags: assert property ( // R22
		(single_wr && !push) |=> $stable(ecc_fix_out))
		else $error("error flags changed by a write");

	a_last_flag: assert property ( // R18
		(pin.req && $stable(pin.strap)) |=> last_addr_out
		== (st_ff.cnt == cnt_last))
		else $error("last-address flag disagrees with counter");

	a_burst_mode: assert property ( // R14
		!pin.req |=> st_ff.mode != mrp_pkg::MRP_BURST)
		else $error("burst mode entered without request");
endmodule

// *** rtl/mrp_sync2.sv ***
// mrp_sync2: two-flop resynchroniser for a bundle of pin levels.
// assumes levels only; pulses shorter than one clock may be missed.
`timescale 1ns/100ps
module mrp_sync2
#(
	parameter int W = 1
)
(
	input wire logic sys_clk_in, // system clock
	input wire logic srst_in, // synchronous reset, high
	input wire logic [W-1:0] d_in, // asynchronous levels
	output logic [W-1:0] q_out // synchronised levels
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mrp_sync_st_t;
	mrp_sync_st_t st_ff;
	mrp_sync_st_t nxt_st;

	// first stage feeds only the second stage
	always_comb
	begin
		nxt_st.s1 = d_in;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign q_out = st_ff.s2;
endmodule

// *** test/mrp_host_model.sv ***
// mrp_host_model: host controller side of the port's data pins.
// assumes the port registers its lane enables on sys_clk_in.
`timescale 1ns/100ps
module mrp_host_model
(
	input wire logic sys_clk_in, // system clock
	input wire logic [15:0] dq_out_in, // port data drive
	input wire logic [1:0] dq_oe_in, // port lane enables
	input wire logic stall_in, // slow host holds off words
	input wire logic byte_mode_in, // strap high: upper lanes grounded
	output logic dq_ready_out, // host takes read words
	output logic [15:0] dq_bus_out // resolved data pins
);
	logic [15:0] last_ff = 16'h0000;
	// floating lanes toggle, save the grounded upper lanes in byte mode, so a stale word never looks valid
	always_ff @(posedge sys_clk_in)
		last_ff <= dq_bus_out;
	// each lane is driven only while its enable is high
	always_comb
	begin
		dq_bus_out[7:0] = dq_oe_in[0] ? dq_out_in[7:0] : ~last_ff[7:0];
		// in byte mode the host grounds the upper lanes
		dq_bus_out[15:8] = dq_oe_in[1] ? dq_out_in[15:8]
			: (byte_mode_in ? 8'h00 : ~last_ff[15:8]);
	end
	// prompt host unless told to stall
	assign dq_ready_out = ~stall_in;
endmodule

// *** test/mrp_port_tb.sv ***
// mrp_port_tb: self-checking bench for the four-die memory port.
// assumes mrp_pkg is compiled first and DEPTH_W is cut to 6.
`timescale 1ns/100ps
module mrp_port_tb;
	localparam logic [15:0] BASE = 16'h5A00;
	logic sys_clk, srst, wr_en, out_en, strap, req, init, term, carry;
	logic flip, stall, rdy, last_addr;
	logic [3:0] ce_n, fix;
	logic [20:0] addr;
	logic [15:0] dq, dq_o, bus;
	logic [1:0] oe;
	logic [15:0] q[$];
	int error_cnt = 0;
	int n_checks = 0;

	mrp_port #(.DEPTH_W(6)) mrp_port_i (.sys_clk_in(sys_clk),
		.srst_in(srst), .die_en_n_in(ce_n), .addr_in(addr),
		.wr_en_in(wr_en), .out_en_in(out_en), .dq_in(dq),
		.byte_width_strap_in(strap), .burst_read_req_in(req),
		.burst_init_in(init), .burst_term_in(term),
		.burst_carry_in(carry), .dq_ready_in(rdy), .ecc_flip_in(flip),
		.dq_out(dq_o), .dq_oe_out(oe), .last_addr_out(last_addr),
		.ecc_fix_out(fix));
	mrp_host_model mrp_host_model_i (.sys_clk_in(sys_clk),
		.dq_out_in(dq_o), .dq_oe_in(oe), .stall_in(stall),
		.byte_mode_in(strap), .dq_ready_out(rdy), .dq_bus_out(bus));

	// 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// pins move 1 ns after the edge, clear of sampling
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// bounded wait: the sync path makes answers late, never unbounded
	task automatic wait_oe(input logic [1:0] v);
		int i;
		i = 0;
		while (oe !== v && i < 20)
		begin
			step(1);
			i++;
		end
		if (oe !== v)
		begin
			error_cnt++;
			$display("[ERR] %0t lane enables never settled", $time);
			conclude();
		end
	endtask

	task automatic pins(input logic [3:0] c, input logic w,
		input logic [20:0] a, input logic [15:0] d);
		ce_n = c;
		wr_en = w;
		addr = a;
		dq = d;
	endtask

	// one write cycle, then deselect long enough to settle
	task automatic write_hw(input logic [3:0] c, input logic [20:0] a,
		input logic [15:0] d, input logic f);
		pins(c, 1'b1, a, d);
		flip = f;
		step(1);
		flip = 1'b0;
		pins(mrp_pkg::CE_NONE, 1'b0, a, d);
		step(4);
		chk({14'h0, oe}, 16'h0000);
	endtask

	task automatic read_hw(input logic [3:0] c, input logic [20:0] a,
		input logic [15:0] exp, input logic [3:0] fx);
		pins(c, 1'b0, a, 16'h0000);
		wait_oe(2'h3);
		chk(bus, exp);
		chk({12'h0, fix}, {12'h0, fx});
		pins(mrp_pkg::CE_NONE, 1'b0, a, 16'h0000);
		step(3);
		chk({14'h0, oe}, 16'h0000);
	endtask

	// keep each new word seen on the pins, in order
	task automatic collect(input int n);
		repeat (n)
		begin
			step(1);
			if (oe === 2'h3 && (q.size() == 0 || q[$] !== bus))
				q.push_back(bus);
		end
	endtask

	// host holds all enables and write low in burst
	task automatic burst_on();
		req = 1'b1;
		pins(mrp_pkg::CE_ALL, 1'b0, 21'h00_0000, 16'h0000);
		init = 1'b1;
		term = 1'b0;
		carry = 1'b1;
	endtask

	// outside burst the sequencing inputs sit at their reset levels
	task automatic burst_off();
		req = 1'b0;
		ce_n = mrp_pkg::CE_NONE;
		init = 1'b0;
		term = 1'b1;
		carry = 1'b0;
		step(4);
	endtask

	// words must climb from BASE; rs restarts, exactly n_exp words
	task automatic check_seq(input int rs, input int n_exp);
		int e;
		int r;
		e = 0;
		r = 0;
		foreach (q[i])
		begin
			if (i > 0 && q[i] === BASE)
			begin
				e = 0;
				r++;
			end
			chk(q[i], BASE + 16'(e));
			e++;
		end
		chk(16'(r), 16'(rs));
		chk(16'(q.size()), 16'(n_exp));
		q.delete();
	endtask

	task automatic sc_dies();
		logic [3:0] tab[4];
		tab = '{mrp_pkg::CE_DIE0, mrp_pkg::CE_DIE1, mrp_pkg::CE_DIE2,
			mrp_pkg::CE_DIE3};
		for (int d = 0; d < 4; d++)
			write_hw(tab[d], 21'h00_0014, 16'h3C00 | 16'(d), 1'b0);
		for (int d = 0; d < 4; d++)
			read_hw(tab[d], 21'h00_0014, 16'h3C00 | 16'(d), 4'h0);
	endtask

	// write, output enable and deselect each float the lanes
	task automatic sc_float();
		pins(mrp_pkg::CE_DIE1, 1'b0, 21'h00_0014, 16'h3C01);
		wait_oe(2'h3);
		wr_en = 1'b1;
		step(3);
		chk({14'h0, oe}, 16'h0000);
		wr_en = 1'b0;
		wait_oe(2'h3);
		chk(bus, 16'h3C01);
		out_en = 1'b0;
		step(3);
		chk({14'h0, oe}, 16'h0000);
		out_en = 1'b1;
		wait_oe(2'h3);
		ce_n = mrp_pkg::CE_NONE;
		step(3);
		chk({14'h0, oe}, 16'h0000);
	endtask

	// a flipped stored bit comes back corrected and flagged per die
	task automatic sc_ecc();
		write_hw(mrp_pkg::CE_DIE2, 21'h00_0009, 16'hC35A, 1'b1);
		read_hw(mrp_pkg::CE_DIE2, 21'h00_0009, 16'hC35A, 4'h4);
		read_hw(mrp_pkg::CE_DIE3, 21'h00_0014, 16'h3C03, 4'h4);
		read_hw(mrp_pkg::CE_DIE2, 21'h00_0014, 16'h3C02, 4'h0);
	endtask

	// terminate mid-burst clears the counter and skips reads
	task automatic sc_burst();
		burst_on();
		collect(5);
		chk({15'h0, last_addr}, 16'h0000);
		term = 1'b1;
		collect(1);
		term = 1'b0;
		collect(6);
		burst_off();
		check_seq(1, 8);
	endtask

	// slow host fills the buffer; no word lost or repeated
	task automatic sc_stall();
		burst_on();
		collect(3);
		stall = 1'b1;
		collect(6);
		stall = 1'b0;
		collect(5);
		burst_off();
		check_seq(0, 5);
		burst_on();
		carry = 1'b0;
		collect(5);
		chk(16'(q.size()), 16'h0000);
		carry = 1'b1;
		collect(5);
		burst_off();
		check_seq(0, 2);
	endtask

	// mid-run reset into byte mode; the unwritten byte of the halfword must survive
	task automatic sc_byte();
		srst = 1'b1;
		strap = 1'b1;
		step(4);
		srst = 1'b0;
		step(2);
		chk({dq_o[13:0], oe}, 16'h0000);
		write_hw(mrp_pkg::CE_DIE1, 21'h00_0029, 16'h00A5, 1'b0);
		pins(mrp_pkg::CE_DIE1, 1'b0, 21'h00_0029, 16'h0000);
		wait_oe(2'h1);
		chk(bus, 16'h00A5);
		pins(mrp_pkg::CE_DIE1, 1'b0, 21'h00_0028, 16'h0000);
		step(5);
		chk(bus, 16'h0001);
		chk({14'h0, oe}, 16'h0001);
		ce_n = mrp_pkg::CE_NONE;
		step(3);
		chk({14'h0, oe}, 16'h0000);
	endtask

	initial
	begin
		srst = 1'b1;
		strap = 1'b0;
		out_en = 1'b1;
		flip = 1'b0;
		stall = 1'b0;
		req = 1'b0;
		init = 1'b0;
		term = 1'b1;
		carry = 1'b0;
		pins(mrp_pkg::CE_NONE, 1'b0, 21'h00_0000, 16'h0000);
		step(8);
		srst = 1'b0;
		chk({dq_o[13:0], oe}, 16'h0000);
		chk({11'h0, last_addr, fix}, 16'h0000);
		for (int i = 0; i < 8; i++)
			write_hw(mrp_pkg::CE_DIE0, 21'(i), BASE + 16'(i), 1'b0);
		sc_dies();
		sc_float();
		sc_ecc();
		sc_burst();
		sc_stall();
		sc_byte();
		conclude();
	end
endmodule
